/* File: design/bus_bridge_pkg.sv */
// Constants, field positions and carrier types of the processor bus bridge.
// Assumes one 100 MHz clock; every processor and backplane pin is asynchronous to it.
package bus_bridge_pkg;

    // Memory control latch: I/O port and data bit positions
    localparam logic [7:0] MEM_CTL_PORT = 8'hfc;
    localparam int MAP_LOW_BIT = 2;
    localparam int MAP_HIGH_BIT = 3;
    localparam int ZERO_PAR_BIT = 4;
    localparam int KILL_PAR_BIT = 5;
    localparam logic MEM_CTL_CLEAR = 1'h0;

    // High-address register
    localparam logic [7:0] HIGH_ADDR_RESET = 8'h00;
    localparam logic [3:0] BLOCKED_NIBBLE = 4'h0;

    // Monitor ROM window: top 8K of a 64K page or of the 1M space
    localparam int ROM_WINDOW_LSB = 13;
    localparam int PAGE_MSB = 15;
    localparam int SPACE_MSB = 19;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] ADDR_ZERO = 16'h0000;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        MAP_EVERYWHERE,
        MAP_TOP_PAGE,
        MAP_TOP_MEG,
        MAP_OFF
    } rom_map_t;

    // Processor and backplane pins, sampled together
    typedef struct packed {
        logic wideCpuAddrStrobe;
        logic cpuWriteStrobe;
        logic cpuReadStrobe;
        logic dataInStrobe;
        logic ioCycle;
        logic highAddrPortSelect;
        logic wideCpuActive;
        logic addrDisable_n;
        logic dataOutDisable_n;
        logic [7:0] muxedAddrData;
        logic [7:0] cpuMidAddr;
        logic [3:0] cpuUpperAddr;
        logic [7:0] dataInBus;
    } pins_t;

    typedef struct packed {
        logic prevWrite;
        logic romMapSelLow;
        logic romMapSelHigh;
        logic zeroParity_n;
        logic killParity_n;
        logic [15:0] addrLatch;
        logic [7:0] extAddr;
        logic [7:0] highAddr;
        logic [7:0] dataOut;
        logic monitorRomSelect;
        logic phantomOe_n;
        logic [7:0] adOut;
        logic adOe_n;
        logic addrOe_n;
        logic dataOutOe_n;
    } state_t;

endpackage

/* File: design/cpu_bus_rom_map_and_address_latch.sv */
// Processor-side bus bridge: address/data latches, monitor ROM mapping,
// phantom drive and 24-bit address extension.
// Assumes all processor and backplane pins are asynchronous; each but the unused phantomIn is synchronised.
// What this block does
// - Reset clears the memory control latch; both map-select bits start at zero.
// - Both map bits zero: ROM select asserts on every memory read.
// - High bit only: ROM answers in top 8K of the 1M space.
// - Low bit only: ROM answers in top 8K of every 64K page.
// - Both map bits one: ROM select never asserts.
// - Byte written to port FC: bit 2 loads low, bit 3 high map bit.
// - ROM select asserted pulls the open-collector phantom line low.
// - Reset mapping: reads come from ROM, writes reach RAM.
// - Address latch follows while strobe high, holds once it falls.
// - Address disable low tri-states the address latch outputs.
// - Write data latch follows during write strobe, holds at its end.
// - Data-out disable low tri-states the write data latch outputs.
// - Processor read enables buffer driving data-in onto muxed lines.
// - Wide processor: upper address captured onto A16-A19 at each strobe.
// - A20-A23 come from the high-address register, zero while cleared.
// - High-address port write latches bits 4-7 at write strobe end.
// - Wide processor active: bits 0-3 blocked from high-address register.
// - Narrow processor: low high-address nibble drives A16-A19.
// - High-address register reaches output latch at next address strobe.
// - High-address register changes only on port write or reset.
// - Same latch bit 4 zero forces parity zero, bit 5 zero kills errors.
`timescale 1ns/100ps
module cpu_bus_rom_map_and_address_latch
    import bus_bridge_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Processor strobes and cycle type
    input wire logic wideCpuAddrStrobe,
    input wire logic cpuWriteStrobe,
    input wire logic cpuReadStrobe,
    input wire logic dataInStrobe,
    input wire logic ioCycle,
    input wire logic highAddrPortSelect,
    input wire logic wideCpuActive,
    // Processor address and multiplexed data
    input wire logic [7:0] muxedAddrDataIn,
    output logic [7:0] muxedAddrDataOut,
    output logic muxedAddrDataOe_n,
    input wire logic [7:0] cpuMidAddr,
    input wire logic [3:0] cpuUpperAddr,
    // Backplane address
    input wire logic addrDisable_n,
    output logic [15:0] busAddr,
    output logic [7:0] busExtAddr,
    output logic busAddrOe_n,
    // Backplane data
    input wire logic dataOutDisable_n,
    output logic [7:0] dataOutBus,
    output logic dataOutBusOe_n,
    input wire logic [7:0] dataInBus,
    // Monitor ROM, phantom line and parity control
    output logic monitorRomSelect,
    input wire logic phantomIn,
    output logic phantomOut,
    output logic phantomOe_n,
    output logic zeroParity_n,
    output logic killParity_n
);
    localparam state_t STATE_RESET = '{
        prevWrite: 1'b0,
        romMapSelLow: MEM_CTL_CLEAR,
        romMapSelHigh: MEM_CTL_CLEAR,
        zeroParity_n: MEM_CTL_CLEAR,
        killParity_n: MEM_CTL_CLEAR,
        addrLatch: ADDR_ZERO,
        extAddr: BYTE_ZERO,
        highAddr: HIGH_ADDR_RESET,
        dataOut: BYTE_ZERO,
        monitorRomSelect: 1'b0,
        phantomOe_n: 1'b1,
        adOut: BYTE_ZERO,
        adOe_n: 1'b1,
        addrOe_n: 1'b1,
        dataOutOe_n: 1'b1
    };

    pins_t pinsRaw;
    pins_t pins;
    state_t s;
    state_t next_s;
    logic writeEnd;
    logic [19:0] fullAddr;
    logic memCtlWrite;
    logic highAddrWrite;
    rom_map_t romMap;

    // All checks run on the bridge clock and rest during reset
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Decodes the map-select pair into a mapping mode
    function automatic rom_map_t mapMode(input logic selHigh, input logic selLow);
        rom_map_t m;
        unique case ({selHigh, selLow})
            2'b00: m = MAP_EVERYWHERE;
            2'b01: m = MAP_TOP_PAGE;
            2'b10: m = MAP_TOP_MEG;
            2'b11: m = MAP_OFF;
        endcase
        return m;
    endfunction

    // True when the ROM answers at this 20-bit address
    function automatic logic romHit(input rom_map_t m, input logic [19:0] a);
        logic hit;
        unique case (m)
            MAP_EVERYWHERE: hit = 1'b1;
            MAP_TOP_PAGE: hit = &a[PAGE_MSB:ROM_WINDOW_LSB];
            MAP_TOP_MEG: hit = &a[SPACE_MSB:ROM_WINDOW_LSB];
            MAP_OFF: hit = 1'b0;
        endcase
        return hit;
    endfunction

    assign pinsRaw = '{
        wideCpuAddrStrobe: wideCpuAddrStrobe,
        cpuWriteStrobe: cpuWriteStrobe,
        cpuReadStrobe: cpuReadStrobe,
        dataInStrobe: dataInStrobe,
        ioCycle: ioCycle,
        highAddrPortSelect: highAddrPortSelect,
        wideCpuActive: wideCpuActive,
        addrDisable_n: addrDisable_n,
        dataOutDisable_n: dataOutDisable_n,
        muxedAddrData: muxedAddrDataIn,
        cpuMidAddr: cpuMidAddr,
        cpuUpperAddr: cpuUpperAddr,
        dataInBus: dataInBus
    };

    pin_sync #(
        .WIDTH($bits(pins_t))
    ) pinSync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinIn(pinsRaw),
        .syncOut(pins)
    );

    // Trailing edge of the processor write strobe
    assign writeEnd = s.prevWrite && !pins.cpuWriteStrobe;
    assign fullAddr = {s.extAddr[3:0], s.addrLatch};
    assign romMap = mapMode(s.romMapSelHigh, s.romMapSelLow);
    assign memCtlWrite = writeEnd && pins.ioCycle && (s.addrLatch[7:0] == MEM_CTL_PORT);
    assign highAddrWrite = writeEnd && pins.highAddrPortSelect;

    always_comb begin
        next_s = s;
        next_s.prevWrite = pins.cpuWriteStrobe;

        if (pins.wideCpuAddrStrobe) begin
            next_s.addrLatch = {pins.cpuMidAddr, pins.muxedAddrData};
            next_s.extAddr[7:4] = s.highAddr[7:4];
            next_s.extAddr[3:0] = pins.wideCpuActive ? pins.cpuUpperAddr : s.highAddr[3:0];
        end

        if (pins.cpuWriteStrobe) begin
            next_s.dataOut = pins.muxedAddrData;
        end

        // map and parity bits load as the port write ends
        if (memCtlWrite) begin
            next_s.romMapSelLow = s.dataOut[MAP_LOW_BIT];
            next_s.romMapSelHigh = s.dataOut[MAP_HIGH_BIT];
            next_s.zeroParity_n = s.dataOut[ZERO_PAR_BIT];
            next_s.killParity_n = s.dataOut[KILL_PAR_BIT];
        end

        if (highAddrWrite) begin
            next_s.highAddr[7:4] = s.dataOut[7:4];
            // Wide processor brings its own A16-A19, so this nibble is dead
            next_s.highAddr[3:0] = pins.wideCpuActive ? BLOCKED_NIBBLE : s.dataOut[3:0];
        end

        // read buffer onto the multiplexed lines
        next_s.adOe_n = !pins.cpuReadStrobe;
        if (pins.cpuReadStrobe) begin
            next_s.adOut = pins.dataInBus;
        end

        // only memory reads may select the ROM
        next_s.monitorRomSelect = pins.dataInStrobe && !pins.ioCycle
            && romHit(romMap, fullAddr);
        next_s.phantomOe_n = !next_s.monitorRomSelect;

        // release lines to a backplane master
        next_s.addrOe_n = !pins.addrDisable_n;
        next_s.dataOutOe_n = !pins.dataOutDisable_n;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign muxedAddrDataOut = s.adOut;
    assign muxedAddrDataOe_n = s.adOe_n;
    assign busAddr = s.addrLatch;
    assign busExtAddr = s.extAddr;
    assign busAddrOe_n = s.addrOe_n;
    assign dataOutBus = s.dataOut;
    assign dataOutBusOe_n = s.dataOutOe_n;
    assign monitorRomSelect = s.monitorRomSelect;
    // Open collector: released level follows the enable, so a pull is always low
    assign phantomOut = s.phantomOe_n;
    assign phantomOe_n = s.phantomOe_n;
    assign zeroParity_n = s.zeroParity_n;
    assign killParity_n = s.killParity_n;

    property p_mapClearAfterReset;
        $past(!rst_n) |-> !s.romMapSelLow && !s.romMapSelHigh;
    endproperty
    a_mapClearAfterReset: assert property (p_mapClearAfterReset)
        else $error("map-select bits not clear after reset");

    property p_romEverywhere;
        !s.romMapSelLow && !s.romMapSelHigh && pins.dataInStrobe && !pins.ioCycle |=> s.monitorRomSelect;
    endproperty
    a_romEverywhere: assert property (p_romEverywhere)
        else $error("memory read missed the ROM in the reset mapping");

    property p_romOff;
        s.romMapSelLow && s.romMapSelHigh |=> !s.monitorRomSelect;
    endproperty
    a_romOff: assert property (p_romOff)
        else $error("ROM selected while mapping is off");

    property p_writeNoRom;
        pins.cpuWriteStrobe && !pins.dataInStrobe |=> !s.monitorRomSelect;
    endproperty
    a_writeNoRom: assert property (p_writeNoRom)
        else $error("ROM selected on a write");

    property p_phantomPull;
        s.monitorRomSelect |-> !phantomOe_n && !phantomOut;
    endproperty
    a_phantomPull: assert property (p_phantomPull)
        else $error("phantom line not pulled while ROM selected");

    property p_addrFollows;
        pins.wideCpuAddrStrobe |=> s.addrLatch == $past({pins.cpuMidAddr, pins.muxedAddrData});
    endproperty
    a_addrFollows: assert property (p_addrFollows)
        else $error("address latch not transparent during strobe");

    property p_addrHolds;
        !pins.wideCpuAddrStrobe |=> $stable(s.addrLatch);
    endproperty
    a_addrHolds: assert property (p_addrHolds)
        else $error("address latch moved without strobe");

    property p_writeDataHolds;
        !pins.cpuWriteStrobe |=> $stable(s.dataOut);
    endproperty
    a_writeDataHolds: assert property (p_writeDataHolds)
        else $error("write data latch moved without strobe");

    property p_readBuffer;
        pins.cpuReadStrobe |=> !s.adOe_n && s.adOut == $past(pins.dataInBus);
    endproperty
    a_readBuffer: assert property (p_readBuffer)
        else $error("read data not driven onto multiplexed lines");

    property p_upperAddrCapture;
        pins.wideCpuAddrStrobe && pins.wideCpuActive |=> s.extAddr[3:0] == $past(pins.cpuUpperAddr);
    endproperty
    a_upperAddrCapture: assert property (p_upperAddrCapture)
        else $error("wide processor upper address not captured");

    property p_wideNibbleBlocked;
        highAddrWrite && pins.wideCpuActive |=> s.highAddr[3:0] == BLOCKED_NIBBLE;
    endproperty
    a_wideNibbleBlocked: assert property (p_wideNibbleBlocked)
        else $error("low nibble reached high-address register");

    property p_highAddrOnlyByPort;
        !highAddrWrite |=> $stable(s.highAddr);
    endproperty
    a_highAddrOnlyByPort: assert property (p_highAddrOnlyByPort)
        else $error("high-address register changed without a port write");
endmodule

/* File: design/pin_sync.sv */
// Two-stage synchroniser for a word of independent pin levels.
// Assumes each bit is a level; multi-bit words are only used once stable.
`timescale 1ns/100ps
module pin_sync
    import bus_bridge_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Pins in, synchronised levels out
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage [SYNC_STAGES];

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stage[0] <= '0;
            stage[1] <= '0;
        end else begin
            stage[0] <= pinIn;
            stage[1] <= stage[0];
        end
    end

    assign syncOut = stage[1];
endmodule

/* File: dv/cpu_bus_rom_map_and_address_latch_tb.sv */
// Self-checking bench for the processor bus bridge, with a reference model.
// Assumes pins are synchronised, so results are looked at six cycles on.
`timescale 1ns/100ps
module cpu_bus_rom_map_and_address_latch_tb
    import bus_bridge_pkg::*;
;
    logic mclk = 0;
    logic rst_n = 0;
    logic wideCpuAddrStrobe, cpuWriteStrobe, cpuReadStrobe, dataInStrobe, ioCycle;
    logic highAddrPortSelect, wideCpuActive, addrDisable_n, dataOutDisable_n, phantomIn;
    logic [7:0] muxedAddrDataIn, cpuMidAddr, dataInBus, muxedAddrDataOut, dataOutBus, busExtAddr;
    logic [3:0] cpuUpperAddr;
    logic [15:0] busAddr;
    logic muxedAddrDataOe_n, busAddrOe_n, dataOutBusOe_n, monitorRomSelect;
    logic phantomOut, phantomOe_n, zeroParity_n, killParity_n;
    int nMismatch = 0;
    int samplesChecked = 0;
    int mapMode = 0;
    int hi = 0;
    int probe[5] = '{'hfe000, 'hfdfff, 'h3e000, 'h3dfff, 0};

    cpu_bus_rom_map_and_address_latch dut (.mclk, .rst_n, .wideCpuAddrStrobe, .cpuWriteStrobe,
        .cpuReadStrobe, .dataInStrobe, .ioCycle, .highAddrPortSelect, .wideCpuActive,
        .muxedAddrDataIn, .muxedAddrDataOut, .muxedAddrDataOe_n, .cpuMidAddr, .cpuUpperAddr,
        .addrDisable_n, .busAddr, .busExtAddr, .busAddrOe_n, .dataOutDisable_n, .dataOutBus,
        .dataOutBusOe_n, .dataInBus, .monitorRomSelect, .phantomIn, .phantomOut,
        .phantomOe_n, .zeroParity_n, .killParity_n);
    phantom_line_model backplane (.phantomOut, .phantomOe_n, .phantomIn);

    initial forever #5 mclk = !mclk;

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic gap(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic wrapUp();
        $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // One machine cycle; expectations come from the model state at strobe time
    task automatic busCycle(input bit io, input bit wr, input bit hp, input int a, input int d);
        logic [19:0] ext;
        logic rom;
        ext = wideCpuActive ? 20'((hi & 'hf0) | ((a >> 16) & 'hf)) : 20'(hi);
        rom = !wr && !io && (mapMode == 0 || (mapMode == 1 && (a & 'he000) == 'he000)
            || (mapMode == 2 && (ext & 'hf) == 'hf && (a & 'he000) == 'he000));
        ioCycle = io;
        highAddrPortSelect = hp;
        {cpuUpperAddr, cpuMidAddr, muxedAddrDataIn} = a[19:0];
        addrDisable_n = 1'($urandom_range(1));
        dataOutDisable_n = 1'($urandom_range(1));
        dataInBus = 8'($urandom);
        wideCpuAddrStrobe = 1;
        gap(6);
        wideCpuAddrStrobe = 0;
        gap(2);
        muxedAddrDataIn = 8'($urandom);
        gap(6);
        chk(20'(busAddr), 20'(a[15:0]));
        chk(20'(busAddrOe_n), 20'(!addrDisable_n));
        chk(20'(busExtAddr), ext);
        muxedAddrDataIn = d[7:0];
        cpuWriteStrobe = wr;
        cpuReadStrobe = !wr;
        dataInStrobe = !wr;
        gap(6);
        chk(20'(muxedAddrDataOe_n), 20'(wr));
        if (!wr) chk(20'(muxedAddrDataOut), 20'(dataInBus));
        chk(20'(monitorRomSelect), 20'(rom));
        chk(20'(phantomIn), 20'(!rom));
        {cpuWriteStrobe, cpuReadStrobe, dataInStrobe} = 3'h0;
        gap(6);
        if (wr) chk(20'(dataOutBus), 20'(d[7:0]));
        if (wr) chk(20'(dataOutBusOe_n), 20'(!dataOutDisable_n));
        if (wr && io && a[7:0] == MEM_CTL_PORT) begin
            mapMode = d[3:2];
            chk(20'({killParity_n, zeroParity_n}), 20'(d[5:4]));
        end
        if (wr && hp) hi = wideCpuActive ? (d & 'hf0) : (d & 'hff);
    endtask

    initial begin
        void'($urandom(31754));
        {wideCpuAddrStrobe, cpuWriteStrobe, cpuReadStrobe, dataInStrobe, ioCycle} = 5'h0;
        {highAddrPortSelect, wideCpuActive, muxedAddrDataIn, cpuMidAddr} = 18'h0;
        {cpuUpperAddr, dataInBus} = 12'h0;
        {addrDisable_n, dataOutDisable_n} = 2'h3;
        repeat (20) @(negedge mclk);
        rst_n = 1;
        gap(4);
        // Reset mapping: any read hits the ROM, writes go to RAM
        repeat (6) busCycle(0, 1'($urandom_range(1)), 0, $urandom, $urandom);
        // Every mapping, probed on both sides of each window edge
        for (int m = 3; m >= 0; m--) begin
            // Top-meg window needs the wide processor's own A16-A19
            wideCpuActive = (m == 2) ? 1'b1 : 1'($urandom_range(1));
            busCycle(1, 1, 0, MEM_CTL_PORT, ($urandom & 'hf3) | (m << 2));
            foreach (probe[i]) busCycle(0, 0, 0, probe[i], 0);
            busCycle(0, 0, 0, $urandom, 0);
        end
        // High-address register under both processor widths
        repeat (10) begin
            wideCpuActive = 1'($urandom_range(1));
            busCycle(1, 1, 1, $urandom & 'hff, $urandom);
            busCycle(0, 1'($urandom_range(1)), 0, $urandom, $urandom);
        end
        wrapUp();
    end

    // Hang guard, well beyond the roughly 1400 cycles the run needs
    initial begin
        #200us;
        nMismatch++;
        wrapUp();
    end
endmodule

/* File: dv/phantom_line_model.sv */
// Backplane side of the phantom line: open-collector wire with pull-up.
// Assumes the bridge is the only board pulling the line in this bench.
`timescale 1ns/100ps
module phantom_line_model (
    // Bridge drive
    input wire logic phantomOut,
    input wire logic phantomOe_n,
    // Resolved wire
    output logic phantomIn
);
    assign phantomIn = (!phantomOe_n && !phantomOut) ? 1'b0 : 1'b1;
endmodule
